// ---- acls_pkg.sv ----
// Package: constants, opcodes and helpers of the accumulator load/store unit
// Contract
// - Double-word load fills all 32 bits from two words or an immediate.
// - Negative flag follows the sign of every loaded accumulator value.
// - Zero-load flag is set when a load puts zero in the accumulator.
// - A load after a load in the same scan pushes the old accumulator before writing.
// - Bit-field load gathers one to thirty-two adjacent discrete bits.
// - Accumulator bits above the bit-field count are zero.
// - Octal-converted load turns an octal operand into a 16-bit binary.
// - Indexed load reads word at base plus top stack entry offset.
// - Indexed load forces the upper accumulator half to zero.
// - Constant-table load picks an area constant by stack top, low half.
// - Real load moves a float from two words or an immediate.
// - Real operands are 32-bit IEEE values, in two words or one immediate.
// - Word store writes low accumulator half, direct or via pointer.
// - Eight-entry stack; push shifts down and drops the deepest entry.
// - A store cancels the pending push for the next load.
// - Accumulator clears to zero at every scan end.
package acls_pkg;

	localparam int          ACLS_ACC_W       = 32;
	localparam int          ACLS_WORD_W      = 16;
	localparam int          ACLS_STACK_DEPTH = 8;
	localparam int          ACLS_CNT_W       = 6;
	localparam logic [5:0]  ACLS_BF_LAST_IDX = 6'h1f;
	localparam logic [31:0] ACLS_ACC_RESET   = 32'h0000_0000;
	localparam logic [15:0] ACLS_WORD_STEP   = 16'h0001;
	localparam logic [5:0]  ACLS_IDX_STEP    = 6'h01;

	// Instruction codes from the sequencer
	typedef enum logic [2:0] {
		OP_DOUBLE  = 3'h0,
		OP_BITS    = 3'h1,
		OP_OCTAL   = 3'h2,
		OP_INDEXED = 3'h3,
		OP_TABLE   = 3'h4,
		OP_REAL    = 3'h5,
		OP_STORE   = 3'h6
	} acls_op_t;

	// Every instruction but the store counts as a load
	function automatic logic acls_is_load(input acls_op_t op);
		acls_is_load = (op != OP_STORE);
	endfunction : acls_is_load

	// Octal digits come one per nibble; keep three bits of each
	function automatic logic [15:0] acls_oct2bin(input logic [31:0] v);
		logic [17:0] b;
		b = {v[22:20], v[18:16], v[14:12], v[10:8], v[6:4], v[2:0]};
		acls_oct2bin = b[15:0];
	endfunction : acls_oct2bin

endpackage : acls_pkg

// ---- acls_stk_if.sv ----
// Interface: link between the load/store control and the accumulator stack
`timescale 1ns/1ps
interface acls_stk_if
	import acls_pkg::*;
	#(parameter int WIDTH = ACLS_ACC_W);

	logic             push;
	logic [WIDTH-1:0] push_data;
	logic [WIDTH-1:0] top;
	logic [WIDTH-1:0] second;

	modport ctrl (output push, output push_data, input top, input second);
	modport stack (input push, input push_data, output top, output second);

endinterface : acls_stk_if

// ---- acls_stack.sv ----
// Eight-level accumulator stack, push only
`timescale 1ns/1ps
module acls_stack
	import acls_pkg::*;
	#(
	parameter int DEPTH = ACLS_STACK_DEPTH,
	parameter int WIDTH = ACLS_ACC_W
	)
	(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Control side
	acls_stk_if.stack stk
	);

	logic [WIDTH-1:0] lvl_q [DEPTH];
	logic [WIDTH-1:0] lvl_d [DEPTH];

	// Push shifts every level down; deepest entry falls off
	always_comb
	begin
		for (int i = 0; i < DEPTH; i++)
			lvl_d[i] = lvl_q[i];
		if (stk.push)
		begin
			lvl_d[0] = stk.push_data;
			for (int i = 1; i < DEPTH; i++)
				lvl_d[i] = lvl_q[i-1];
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < DEPTH; i++)
				lvl_q[i] <= ACLS_ACC_RESET;
		end
		else
		begin
			for (int i = 0; i < DEPTH; i++)
				lvl_q[i] <= lvl_d[i];
		end
	end

	assign stk.top    = lvl_q[0];
	assign stk.second = lvl_q[1];

	a_push_top: assert property (@(posedge clk) disable iff (!rstn)
		stk.push |=> lvl_q[0] == $past(stk.push_data))
		else $error("stack top does not hold pushed value");
	a_push_shift: assert property (@(posedge clk) disable iff (!rstn)
		stk.push |=> lvl_q[DEPTH-1] == $past(lvl_q[DEPTH-2]))
		else $error("stack did not shift down on push");

endmodule : acls_stack

// ---- acls_unit.sv ----
// Accumulator load/store unit: control, accumulator and status flags
`timescale 1ns/1ps
module acls_unit
	import acls_pkg::*;
	(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Instruction sequencer
	input  wire logic        op_valid,
	output logic             op_ready,
	input  wire acls_op_t    op_code,
	input  wire logic        op_imm,
	input  wire logic [15:0] op_addr,
	input  wire logic [31:0] op_operand,
	input  wire logic [5:0]  op_count,
	output logic             op_done,
	input  wire logic        scan_end,
	// Word data memory and constant data area
	output logic             mem_re,
	output logic             mem_we,
	output logic [15:0]      mem_addr,
	output logic [15:0]      mem_wdata,
	output logic             mem_const_sel,
	output logic [15:0]      mem_area,
	input  wire logic [15:0] mem_rdata,
	// Discrete bit memory
	output logic             bit_re,
	output logic [15:0]      bit_addr,
	input  wire logic        bit_rdata,
	// Accumulator and status
	output logic [31:0]      acc,
	output logic             negative_flag,
	output logic             zero_load_flag
	);

	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_RD0  = 7'b0000010,
		ST_RD1  = 7'b0000100,
		ST_RD2  = 7'b0001000,
		ST_BITR = 7'b0010000,
		ST_BITC = 7'b0100000,
		ST_WR   = 7'b1000000
	} acls_state_t;

	acls_state_t st_q, st_d;
	acls_op_t    op_q, op_d;
	logic [31:0] acc_q, acc_d, fld_q, fld_d;
	logic [15:0] addr_q, addr_d, area_q, area_d, lo_q, lo_d;
	logic [5:0]  cnt_q, cnt_d, idx_q, idx_d;
	logic        neg_q, neg_d, zero_q, zero_d, pend_q, pend_d;
	logic        ld_done_q, ld_done_d, st_done_q, st_done_d;
	logic        commit;
	logic [31:0] val;
	logic [15:0] offset;

	acls_stk_if #(.WIDTH(ACLS_ACC_W)) stk ();

	acls_stack #(.DEPTH(ACLS_STACK_DEPTH), .WIDTH(ACLS_ACC_W)) i_acls_stack (
		.clk  (clk),
		.rstn (rstn),
		.stk  (stk.stack)
	);

	// Offset is the stack top after this load's push, so bypass the acc
	assign offset = pend_q ? acc_q[15:0] : stk.top[15:0];

	// Sequencing, accumulator and flag update
	always_comb
	begin
		st_d      = st_q;
		op_d      = op_q;
		acc_d     = acc_q;
		fld_d     = fld_q;
		addr_d    = addr_q;
		area_d    = area_q;
		lo_d      = lo_q;
		cnt_d     = cnt_q;
		idx_d     = idx_q;
		neg_d     = neg_q;
		zero_d    = zero_q;
		pend_d    = pend_q;
		ld_done_d = 1'b0;
		st_done_d = 1'b0;
		commit    = 1'b0;
		val       = ACLS_ACC_RESET;
		stk.push      = 1'b0;
		stk.push_data = acc_q;
		case (st_q)
			ST_IDLE:
				if (op_valid)
				begin
					op_d  = op_code;
					cnt_d = op_count;
					idx_d = '0;
					fld_d = ACLS_ACC_RESET;
					// Old value goes down only if no store came between
					stk.push = acls_is_load(op_code) && pend_q;
					case (op_code)
						OP_DOUBLE, OP_REAL:
							if (op_imm)
							begin
								commit = 1'b1;
								val    = op_operand;
							end
							else
							begin
								addr_d = op_addr;
								st_d   = ST_RD0;
							end
						OP_OCTAL:
						begin
							commit = 1'b1;
							val    = {16'h0000, acls_oct2bin(op_operand)};
						end
						OP_INDEXED:
						begin
							addr_d = 16'(op_addr + offset);
							st_d   = ST_RD0;
						end
						OP_TABLE:
						begin
							addr_d = offset;
							area_d = op_addr;
							st_d   = ST_RD0;
						end
						OP_BITS:
						begin
							addr_d = op_addr;
							st_d   = ST_BITR;
						end
						OP_STORE:
						begin
							pend_d = 1'b0;
							addr_d = op_addr;
							st_d   = op_imm ? ST_RD0 : ST_WR;
						end
						default: st_d = ST_IDLE;
					endcase
				end
			ST_RD0:
			begin
				if (op_q == OP_DOUBLE || op_q == OP_REAL)
					addr_d = 16'(addr_q + ACLS_WORD_STEP);
				st_d = ST_RD1;
			end
			ST_RD1:
				if (op_q == OP_DOUBLE || op_q == OP_REAL)
				begin
					lo_d = mem_rdata;
					st_d = ST_RD2;
				end
				else if (op_q == OP_STORE)
				begin
					addr_d = mem_rdata;
					st_d   = ST_WR;
				end
				else
				begin
					commit = 1'b1;
					val    = {16'h0000, mem_rdata};
				end
			ST_RD2:
			begin
				commit = 1'b1;
				val    = {mem_rdata, lo_q};
			end
			ST_BITR: st_d = ST_BITC;
			ST_BITC:
			begin
				// Start bit to bit 0; untouched positions stay zero
				fld_d = fld_q | ({31'h0, bit_rdata} << idx_q);
				if (idx_q + ACLS_IDX_STEP >= cnt_q || idx_q == ACLS_BF_LAST_IDX)
				begin
					commit = 1'b1;
					val    = fld_d;
				end
				else
				begin
					idx_d  = 6'(idx_q + ACLS_IDX_STEP);
					addr_d = 16'(addr_q + ACLS_WORD_STEP);
					st_d   = ST_BITR;
				end
			end
			ST_WR:
			begin
				st_done_d = 1'b1;
				st_d      = ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
		if (commit)
		begin
			acc_d     = val;
			neg_d     = val[31];
			zero_d    = (val == ACLS_ACC_RESET);
			pend_d    = 1'b1;
			ld_done_d = 1'b1;
			st_d      = ST_IDLE;
		end
		// Scan end wins over a finishing load; flags keep the loaded value
		if (scan_end)
		begin
			acc_d  = ACLS_ACC_RESET;
			pend_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_q      <= ST_IDLE;
			op_q      <= OP_DOUBLE;
			acc_q     <= ACLS_ACC_RESET;
			fld_q     <= ACLS_ACC_RESET;
			addr_q    <= '0;
			area_q    <= '0;
			lo_q      <= '0;
			cnt_q     <= '0;
			idx_q     <= '0;
			neg_q     <= 1'b0;
			zero_q    <= 1'b0;
			pend_q    <= 1'b0;
			ld_done_q <= 1'b0;
			st_done_q <= 1'b0;
		end
		else
		begin
			st_q      <= st_d;
			op_q      <= op_d;
			acc_q     <= acc_d;
			fld_q     <= fld_d;
			addr_q    <= addr_d;
			area_q    <= area_d;
			lo_q      <= lo_d;
			cnt_q     <= cnt_d;
			idx_q     <= idx_d;
			neg_q     <= neg_d;
			zero_q    <= zero_d;
			pend_q    <= pend_d;
			ld_done_q <= ld_done_d;
			st_done_q <= st_done_d;
		end
	end

	// Strobes decode from state; address and data come from flops
	assign op_ready       = (st_q == ST_IDLE);
	assign op_done        = ld_done_q | st_done_q;
	assign mem_re         = (st_q == ST_RD0) || (st_q == ST_RD1 &&
	                        (op_q == OP_DOUBLE || op_q == OP_REAL));
	assign mem_we         = (st_q == ST_WR);
	assign mem_addr       = addr_q;
	assign mem_wdata      = acc_q[15:0];
	assign mem_const_sel  = (op_q == OP_TABLE) && (st_q != ST_IDLE);
	assign mem_area       = area_q;
	assign bit_re         = (st_q == ST_BITR);
	assign bit_addr       = addr_q;
	assign acc            = acc_q;
	assign negative_flag  = neg_q;
	assign zero_load_flag = zero_q;

	sequence s_push_req;
		st_q == ST_IDLE && op_valid && acls_is_load(op_code) && pend_q;
	endsequence

	sequence s_store_then_load;
		st_done_q ##1 (st_q == ST_IDLE && op_valid && acls_is_load(op_code));
	endsequence

	a_push_old_acc: assert property (@(posedge clk) disable iff (!rstn)
		s_push_req |=> stk.top == $past(acc_q))
		else $error("earlier accumulator not pushed on load");
	a_store_no_push: assert property (@(posedge clk) disable iff (!rstn)
		s_store_then_load |-> !stk.push)
		else $error("load after store pushed the stack");
	a_neg_flag: assert property (@(posedge clk) disable iff (!rstn)
		ld_done_q && !$past(scan_end) |-> negative_flag == acc_q[31])
		else $error("negative flag disagrees with loaded sign");
	a_zero_flag: assert property (@(posedge clk) disable iff (!rstn)
		ld_done_q && !$past(scan_end) |-> zero_load_flag == (acc_q == '0))
		else $error("zero-load flag disagrees with loaded value");
	a_bits_upper_zero: assert property (@(posedge clk) disable iff (!rstn)
		(ld_done_q && op_q == OP_BITS && cnt_q != '0 && cnt_q <= 6'h20)
		|-> (acc_q >> cnt_q) == ACLS_ACC_RESET)
		else $error("bit-field left bits above the count");
	a_half_upper_zero: assert property (@(posedge clk) disable iff (!rstn)
		(ld_done_q && (op_q == OP_INDEXED || op_q == OP_TABLE ||
		op_q == OP_OCTAL)) |-> acc_q[31:16] == 16'h0000)
		else $error("16-bit load left upper half set");
	a_dword_order: assert property (@(posedge clk) disable iff (!rstn)
		(st_q == ST_RD2) |=> acc_q == {$past(mem_rdata), $past(mem_rdata, 2)}
		|| $past(scan_end))
		else $error("double word halves in wrong order");
	a_scan_clear: assert property (@(posedge clk) disable iff (!rstn)
		scan_end |=> acc_q == ACLS_ACC_RESET && !pend_q)
		else $error("accumulator not cleared at scan end");
	a_store_data: assert property (@(posedge clk) disable iff (!rstn)
		mem_we |-> mem_wdata == acc_q[15:0] ##1 op_done)
		else $error("store wrote wrong data or never finished");

endmodule : acls_unit

// ---- acls_mem_model.sv ----
// Partner model: word memory, constant data area and discrete bit memory
`timescale 1ns/1ps
module acls_mem_model
	(
	// Clock
	input  wire logic        clk,
	// Word memory and constant area
	input  wire logic        mem_re,
	input  wire logic        mem_we,
	input  wire logic [15:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	input  wire logic        mem_const_sel,
	input  wire logic [15:0] mem_area,
	output logic      [15:0] mem_rdata,
	// Bit memory
	input  wire logic        bit_re,
	input  wire logic [15:0] bit_addr,
	output logic             bit_rdata
	);
	logic [15:0] words [0:255];
	logic        bits  [0:255];

	initial
	begin
		mem_rdata = 16'h0000;
		bit_rdata = 1'b0;
	end

	// Read data is valid one cycle after a strobe only; otherwise the
	// lines flip, so a late sample never finds stale data
	always @(posedge clk)
	begin
		if (mem_re && mem_const_sel)
			mem_rdata <= {mem_area[7:0], mem_addr[7:0]} ^ 16'h0f0f;
		else if (mem_re)
			mem_rdata <= words[mem_addr[7:0]];
		else
			mem_rdata <= ~mem_rdata;
		bit_rdata <= bit_re ? bits[bit_addr[7:0]] : ~bit_rdata;
		if (mem_we)
			words[mem_addr[7:0]] <= mem_wdata;
	end
endmodule : acls_mem_model

// ---- acls_unit_tb.sv ----
// Testbench of the accumulator load/store unit
`timescale 1ns/1ps
module acls_unit_tb
	import acls_pkg::*;
	;
	logic        clk, rstn, op_valid, op_imm, scan_end;
	acls_op_t    op_code;
	logic [15:0] op_addr, seen_area, seen_idx;
	logic [31:0] op_operand;
	logic [5:0]  op_count;
	wire         op_ready, op_done, mem_re, mem_we, mem_const_sel;
	wire         bit_re, bit_rdata, negative_flag, zero_load_flag;
	wire  [15:0] mem_addr, mem_wdata, mem_area, mem_rdata, bit_addr;
	wire  [31:0] acc;
	int          miscompares, check_count;

	acls_unit i_acls_unit (.clk(clk), .rstn(rstn), .op_valid(op_valid),
		.op_ready(op_ready), .op_code(op_code), .op_imm(op_imm),
		.op_addr(op_addr), .op_operand(op_operand), .op_count(op_count),
		.op_done(op_done), .scan_end(scan_end), .mem_re(mem_re),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_const_sel(mem_const_sel), .mem_area(mem_area),
		.mem_rdata(mem_rdata), .bit_re(bit_re), .bit_addr(bit_addr),
		.bit_rdata(bit_rdata), .acc(acc), .negative_flag(negative_flag),
		.zero_load_flag(zero_load_flag));

	acls_mem_model i_acls_mem_model (.clk(clk), .mem_re(mem_re),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_const_sel(mem_const_sel), .mem_area(mem_area),
		.mem_rdata(mem_rdata), .bit_re(bit_re), .bit_addr(bit_addr),
		.bit_rdata(bit_rdata));

	// Clock, 4 ns period
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Remember where the last constant-area read went
	always @(posedge clk)
	begin
		if (mem_re === 1'b1 && mem_const_sel === 1'b1)
		begin
			seen_area <= mem_area;
			seen_idx  <= mem_addr;
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task close_out;
		if (miscompares == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out

	// One op: offered while idle, taken at the next edge, then wait done
	task automatic run_op(input acls_op_t c, input logic im,
		input logic [15:0] a, input logic [31:0] d, input logic [5:0] n,
		output int lat);
		@(posedge clk);
		op_valid   <= 1'b1;
		op_code    <= c;
		op_imm     <= im;
		op_addr    <= a;
		op_operand <= d;
		op_count   <= n;
		@(posedge clk);
		op_valid <= 1'b0;
		lat = 1;
		#1;
		while (op_done !== 1'b1 && lat < 200)
		begin
			@(posedge clk);
			#1;
			lat++;
		end
	endtask : run_op

	// Load and judge accumulator, flags and latency
	task automatic ld(input acls_op_t c, input logic im, input logic [15:0] a,
		input logic [31:0] d, input logic [5:0] n, input logic [31:0] ex,
		input int el);
		int lat;
		run_op(c, im, a, d, n, lat);
		chk(acc, ex);
		chk(negative_flag, ex[31]);
		chk(zero_load_flag, ex == 32'h0);
		chk(lat, el);
	endtask : ld

	task scan_pulse;
		@(posedge clk);
		scan_end <= 1'b1;
		@(posedge clk);
		scan_end <= 1'b0;
		#1;
	endtask : scan_pulse

	task t_loads;
		ld(OP_DOUBLE, 1, 0, 32'h8000_0001, 0, 32'h8000_0001, 1);
		ld(OP_DOUBLE, 0, 16'h0010, 0, 0, 32'hf00d_1234, 4);
		ld(OP_REAL, 1, 0, 32'h4049_0fdb, 0, 32'h4049_0fdb, 1);
		ld(OP_REAL, 0, 16'h0020, 0, 0, 32'hc0a0_0000, 4);
		ld(OP_OCTAL, 0, 0, 32'h0004_0400, 0, 32'h0000_4100, 1);
		ld(OP_DOUBLE, 1, 0, 0, 0, 0, 1);
	endtask : t_loads

	// Counts 7, 32 and 1; the last one gathers a zero
	task automatic t_bits;
		int          cnt [3] = '{7, 32, 1};
		int          st [3] = '{5, 0, 64};
		logic [31:0] ex;
		for (int k = 0; k < 3; k++)
		begin
			ex = 32'h0;
			for (int i = 0; i < cnt[k]; i++)
				ex[i] = i_acls_mem_model.bits[st[k] + i];
			ld(OP_BITS, 0, 16'(st[k]), 0, 6'(cnt[k]), ex,
				2 * cnt[k] + 1);
		end
	endtask : t_bits

	// Push, store cancelling the push, indexed offset from stack top
	task automatic t_stack;
		int lat;
		scan_pulse;
		ld(OP_OCTAL, 0, 0, 32'h25, 0, 32'h15, 1);
		ld(OP_OCTAL, 0, 0, 32'h2, 0, 32'h2, 1);
		run_op(OP_STORE, 0, 16'h0040, 0, 0, lat);
		chk(lat, 2);
		chk(i_acls_mem_model.words[8'h40], 16'h0002);
		ld(OP_INDEXED, 0, 16'h0030, 0, 0, 32'h0000_0007, 3);
		ld(OP_INDEXED, 0, 16'h0030, 0, 0, 32'h0000_8abc, 3);
	endtask : t_stack

	task t_table;
		scan_pulse;
		ld(OP_OCTAL, 0, 0, 32'h1, 0, 32'h1, 1);
		ld(OP_TABLE, 0, 16'h0002, 0, 0, 32'h0000_0d0e, 3);
		chk(seen_area, 16'h0002);
		chk(seen_idx, 16'h0001);
	endtask : t_table

	task automatic t_ptr;
		int lat;
		ld(OP_DOUBLE, 1, 0, 32'h1234_beef, 0, 32'h1234_beef, 1);
		run_op(OP_STORE, 1, 16'h0050, 0, 0, lat);
		chk(lat, 4);
		chk(i_acls_mem_model.words[8'h60], 16'hbeef);
	endtask : t_ptr

	task t_scan;
		ld(OP_DOUBLE, 1, 0, 32'h0bad_cafe, 0, 32'h0bad_cafe, 1);
		scan_pulse;
		chk(acc, 32'h0);
	endtask : t_scan

	// Hang guard, far above the roughly 143 cycles the tests take
	initial
	begin
		#20000;
		miscompares++;
		close_out;
	end

	// Memory contents, reset, then the scenarios
	initial
	begin
		rstn       = 1'b0;
		op_valid   = 1'b0;
		op_code    = OP_DOUBLE;
		op_imm     = 1'b0;
		op_addr    = 16'h0000;
		op_operand = 32'h0;
		op_count   = 6'h00;
		scan_end   = 1'b0;
		for (int i = 0; i < 256; i++)
			i_acls_mem_model.bits[i] = i[0] | i[4];
		i_acls_mem_model.words[8'h10] = 16'h1234;
		i_acls_mem_model.words[8'h11] = 16'hf00d;
		i_acls_mem_model.words[8'h20] = 16'h0000;
		i_acls_mem_model.words[8'h21] = 16'hc0a0;
		i_acls_mem_model.words[8'h45] = 16'h0007;
		i_acls_mem_model.words[8'h37] = 16'h8abc;
		i_acls_mem_model.words[8'h50] = 16'h0060;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		t_loads;
		t_bits;
		t_stack;
		t_table;
		t_ptr;
		t_scan;
		close_out;
	end
endmodule : acls_unit_tb
